// *** logic/power_clock_reset_unit.sv ***
// power, clock and reset controller with its seven byte registers on ahb-lite
// assumes supply and pin inputs are asynchronous and pass two flops first
// Notes on behaviour
// - cpu clock divide: 00/11 full, 01 half, 10 quarter
// - clock rate change applies live, no halt
// - fast uart clock gated by bit 3
// - uart clock gate switchable any time
// - supply low: internal reset, all clocks stop
// - supply good: power-up, then reset-out high
// - glitch over 1 ms: reset, reset-out low
// - hard power-down pin low holds reset
// - hard power-down forces pads quasi-bidirectional
// - only hard and soft power-down states
// - power-down request stops clocks, enters stopped
// - eight wake sources, each individually enabled
// - wake honoured only once stopped is reached
// - cpu clock back after oscillator start-up
// - request clears one cycle after clock returns
// - seven byte registers from base offset
// - reset-seen flag set by reset, firmware clears
`timescale 1ns/1ps
`default_nettype none
`include "pcr_regs.svh"
module power_clock_reset_unit
  import pcr_pkg::*;
#(
  parameter int GLITCH_CYCLES  = `GLITCH_CYCLES,
  parameter int STARTUP_CYCLES = `OSC_STARTUP_CYCLES,
  parameter int PWRUP_CYCLES   = `PWRUP_CYCLES
) (
  // clock and reset
  input  wire logic      hclk,
  input  wire logic      hresetn,
  // ahb-lite slave
  input  wire ahb_req_t  ahb_req,
  output ahb_rsp_t       ahb_rsp,
  // supply monitor and pins
  input  wire logic      supply_ok,
  input  wire logic      supply_glitch_low,
  input  wire logic      hard_power_down_n,
  input  wire logic [7:0] wake_src,
  input  wire logic [7:0] gpio_value,
  // clocks and resets out
  output logic           cpu_clk_tick,
  output logic           uart_clk_en,
  output logic           internal_reset,
  output logic           reset_out_n,
  output logic           regulator_soft_pd,
  output logic           ports_disconnect,
  output pad_ctrl_t      pad_ctrl
);

  localparam logic [7:0] SRC_LEVEL_MASK = 8'h07;

  typedef struct packed {
    logic [2:0]   sync_a;
    logic [2:0]   sync_b;
    logic [7:0]   wake_a;
    logic [7:0]   wake_b;
    logic [7:0]   gpio_a;
    logic [7:0]   gpio_b;
    seq_state_t   state;
    logic [31:0]  cnt;
    logic [31:0]  glitch_cnt;
    logic [7:0]   clk_sel;
    logic [7:0]   clk_gate;
    logic [7:0]   wake_lvl;
    logic [7:0]   pwr_ctrl;
    logic [7:0]   wake_en;
    logic         pd_req;
    logic         clk_on_seen;
    logic         dph_valid;
    logic         dph_write;
    logic [15:0]  dph_addr;
    logic [31:0]  hrdata;
    logic         rst_out_n;
    logic         int_rst;
  } pcr_state_t;

  pcr_state_t s_q;
  pcr_state_t s_d;
  logic       clk_run;
  logic       tick;

  clock_divider #(
    .CNT_W (2)
  ) u_div (
    .hclk    (hclk),
    .hresetn (hresetn),
    .run     (clk_run),
    .sel     (s_q.clk_sel[1:0]),
    .tick    (tick)
  );

  function automatic logic [7:0] wake_hits(input logic [7:0] src, input logic [7:0] lvl,
                                           input logic [7:0] en);
    logic [7:0] pol;
    pol = 8'h00;
    // bits 0..2 carry a selectable level, the rest are active high
    pol[0] = ~lvl[0];
    pol[1] = ~lvl[1];
    pol[2] =  lvl[2];
    // pol bit high means the source wakes on a high level
    wake_hits = (((src & ~SRC_LEVEL_MASK) | ((src ~^ pol) & SRC_LEVEL_MASK)) & en);
  endfunction : wake_hits

  always_comb begin
    logic       sup_ok;
    logic       glitch;
    logic       hard_power_down;
    logic       any_rst;
    logic [7:0] rd;
    logic       wr_now;
    logic [7:0] wb;
    sup_ok = s_q.sync_b[0];
    glitch = s_q.sync_b[1];
    hard_power_down    = ~s_q.sync_b[2];
    any_rst = 1'b0;
    rd = 8'h00;
    wr_now = 1'b0;
    wb = 8'h00;
    s_d = s_q;

    // two-flop synchronisers
    s_d.sync_a = {hard_power_down_n, supply_glitch_low, supply_ok};
    s_d.sync_b = s_q.sync_a;
    s_d.wake_a = wake_src;
    s_d.wake_b = s_q.wake_a;
    s_d.gpio_a = gpio_value;
    s_d.gpio_b = s_q.gpio_a;

    if (glitch) begin
      if (s_q.glitch_cnt < GLITCH_CYCLES) begin
        s_d.glitch_cnt = s_q.glitch_cnt + 32'd1;
      end
    end else begin
      s_d.glitch_cnt = '0;
    end

    any_rst = !sup_ok || hard_power_down || (s_q.glitch_cnt >= GLITCH_CYCLES);

    // request drops a cycle after the clock restarts; a fresh request below wins
    if (s_q.clk_on_seen) begin
      s_d.clk_on_seen = 1'b0;
      s_d.pd_req = 1'b0;
    end

    // register write in the data phase
    wr_now = s_q.dph_valid && s_q.dph_write;
    wb = ahb_req.hwdata[7:0];
    if (wr_now) begin
      if (s_q.dph_addr == `OFS_CPU_CLOCK_SELECT) begin
        s_d.clk_sel = wb & `MASK_CLK_SEL;
      end else if (s_q.dph_addr == `OFS_PERIPHERAL_CLOCK_GATE) begin
        s_d.clk_gate = (s_q.clk_gate & ~`MASK_CLK_GATE_RW) | (wb & `MASK_CLK_GATE_RW);
      end else if (s_q.dph_addr == `OFS_WAKE_LEVEL_SELECT) begin
        s_d.wake_lvl = wb & `MASK_WAKE_LEVEL_RW;
      end else if (s_q.dph_addr == `OFS_POWER_CONTROL) begin
        s_d.pwr_ctrl = wb;
      end else if (s_q.dph_addr == `OFS_WAKE_SOURCE_ENABLE) begin
        s_d.wake_en = wb;
      end else if (s_q.dph_addr == `OFS_PD_REQUEST) begin
        if (wb[0] && s_q.state == st_running) begin
          s_d.pd_req = 1'b1;
        end
      end
    end

    // power sequencer; only two low-power states exist
    case (s_q.state)
      st_reset: begin
        s_d.rst_out_n = 1'b0;
        s_d.cnt = '0;
        if (!any_rst) begin
          s_d.state = st_power_up;
        end
      end
      st_power_up: begin
        s_d.cnt = s_q.cnt + 32'd1;
        if (s_q.cnt >= PWRUP_CYCLES - 1) begin
          s_d.state = st_running;
          s_d.rst_out_n = 1'b1;
        end
      end
      st_running: begin
        // the request left over from the last sleep is not a new one
        if (s_q.pd_req && !s_q.clk_on_seen) begin
          s_d.state = st_stopping;
        end
      end
      st_stopping: begin
        s_d.state = st_stopped;
      end
      st_stopped: begin
        s_d.cnt = '0;
        if (|wake_hits(s_q.wake_b, s_q.wake_lvl, s_q.wake_en)) begin
          s_d.state = st_waking;
        end
      end
      st_waking: begin
        s_d.cnt = s_q.cnt + 32'd1;
        if (s_q.cnt >= STARTUP_CYCLES - 1) begin
          s_d.state = st_running;
          s_d.clk_on_seen = 1'b1;
        end
      end
      default: begin
        s_d.state = st_reset;
      end
    endcase

    // reset-seen: set wins over a firmware clear
    if (s_q.state == st_power_up) begin
      s_d.wake_lvl[`BIT_RESET_SEEN] = 1'b1;
    end

    if (any_rst) begin
      s_d.state = st_reset;
      s_d.rst_out_n = 1'b0;
      s_d.pd_req = 1'b0;
      s_d.clk_on_seen = 1'b0;
      s_d.clk_sel = `RST_CPU_CLOCK_SELECT;
      s_d.clk_gate = `RST_PERIPHERAL_CLOCK_GATE;
      s_d.wake_lvl = `RST_WAKE_LEVEL_SELECT;
      s_d.pwr_ctrl = `RST_POWER_CONTROL;
      s_d.wake_en = `RST_WAKE_SOURCE_ENABLE;
    end
    s_d.int_rst = any_rst;

    // ahb address phase capture
    if (ahb_req.hready) begin
      s_d.dph_valid = ahb_req.hsel && ahb_req.htrans[1];
      s_d.dph_write = ahb_req.hwrite;
      s_d.dph_addr = ahb_req.haddr[17:2];
    end

    // read data, unmapped addresses read zero
    if (ahb_req.hready && ahb_req.hsel && ahb_req.htrans[1] && !ahb_req.hwrite) begin
      if (ahb_req.haddr[17:2] == `OFS_CPU_CLOCK_SELECT) begin
        rd = s_q.clk_sel;
      end else if (ahb_req.haddr[17:2] == `OFS_PERIPHERAL_CLOCK_GATE) begin
        rd = s_q.clk_gate;
      end else if (ahb_req.haddr[17:2] == `OFS_WAKE_LEVEL_SELECT) begin
        rd = s_q.wake_lvl;
      end else if (ahb_req.haddr[17:2] == `OFS_POWER_CONTROL) begin
        rd = s_q.pwr_ctrl;
      end else if (ahb_req.haddr[17:2] == `OFS_POWER_STATUS) begin
        rd = {4'h0, (s_q.state == st_stopped), s_q.state};
      end else if (ahb_req.haddr[17:2] == `OFS_WAKE_SOURCE_ENABLE) begin
        rd = s_q.wake_en;
      end else if (ahb_req.haddr[17:2] == `OFS_PD_REQUEST) begin
        rd = {7'h00, s_q.pd_req};
      end
      s_d.hrdata = {24'h00_0000, rd};
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      s_q <= '0;
      s_q.state <= st_reset;
      s_q.clk_sel <= `RST_CPU_CLOCK_SELECT;
      s_q.clk_gate <= `RST_PERIPHERAL_CLOCK_GATE;
      s_q.wake_lvl <= `RST_WAKE_LEVEL_SELECT;
      s_q.pwr_ctrl <= `RST_POWER_CONTROL;
      s_q.wake_en <= `RST_WAKE_SOURCE_ENABLE;
    end else begin
      s_q <= s_d;
    end
  end

  // clocks stop in reset and in soft power-down
  // in the wake cycle the clock runs while the old request still stands
  assign clk_run = (s_q.state == st_running) && (!s_q.pd_req || s_q.clk_on_seen);
  // gated so that no tick leaks out in the cycle a stop takes effect
  assign cpu_clk_tick = tick && clk_run;
  assign uart_clk_en = clk_run && s_q.clk_gate[`BIT_UART_CLK_EN];
  assign internal_reset = s_q.int_rst | (s_q.state == st_reset);
  assign reset_out_n = s_q.rst_out_n;
  assign regulator_soft_pd = (s_q.state == st_stopping) || (s_q.state == st_stopped);
  assign ports_disconnect = ~s_q.sync_b[2];

  always_comb begin
    pad_ctrl = '0;
    if (!s_q.sync_b[2]) begin
      pad_ctrl.gpio_out_en_n = 8'hff;
      pad_ctrl.pad_pullup_enable = 8'hff;
      pad_ctrl.gpio_push_enable = 8'h00;
      pad_ctrl.pad_hold_control = s_q.gpio_b;
    end
  end

  assign ahb_rsp.hrdata = s_q.hrdata;
  assign ahb_rsp.hreadyout = 1'b1;
  assign ahb_rsp.hresp = 1'b0;

endmodule : power_clock_reset_unit
`default_nettype wire

// *** logic/pcr_regs.svh ***
// register offsets, field positions, reset values and timing counts
// assumes a byte-wide register file reached as aligned 32-bit words
`ifndef PCR_REGS_SVH
`define PCR_REGS_SVH

`define OFS_CPU_CLOCK_SELECT      16'h6200
`define OFS_PERIPHERAL_CLOCK_GATE 16'h6201
`define OFS_WAKE_LEVEL_SELECT     16'h6202
`define OFS_POWER_CONTROL         16'h6203
`define OFS_POWER_STATUS          16'h6204
`define OFS_WAKE_SOURCE_ENABLE    16'h6205
`define OFS_PD_REQUEST            16'h6208

`define RST_CPU_CLOCK_SELECT      8'h02
`define RST_PERIPHERAL_CLOCK_GATE 8'h0e
`define RST_WAKE_LEVEL_SELECT     8'h40
`define RST_POWER_CONTROL         8'hc0
`define RST_WAKE_SOURCE_ENABLE    8'h00

`define BIT_UART_CLK_EN    3
`define BIT_RESET_SEEN     6
`define MASK_CLK_SEL       8'h03
`define MASK_CLK_GATE_RW   8'h08
`define MASK_WAKE_LEVEL_RW 8'h57

`define GLITCH_TIME_US     1000
`define OSC_STARTUP_US     2000
`define CLK_MHZ            50
`define GLITCH_CYCLES      (`GLITCH_TIME_US * `CLK_MHZ)
`define OSC_STARTUP_CYCLES (`OSC_STARTUP_US * `CLK_MHZ)
`define PWRUP_CYCLES       16

`endif

// *** logic/pcr_pkg.sv ***
// types shared by the power, clock and reset controller
// no constants here: those live in pcr_regs.svh
`default_nettype none
package pcr_pkg;

  typedef enum logic [2:0] {
    st_reset,
    st_power_up,
    st_running,
    st_stopping,
    st_stopped,
    st_waking
  } seq_state_t;

  typedef struct packed {
    logic        hsel;
    logic [31:0] haddr;
    logic [1:0]  htrans;
    logic        hwrite;
    logic [2:0]  hsize;
    logic [31:0] hwdata;
    logic        hready;
  } ahb_req_t;

  typedef struct packed {
    logic [31:0] hrdata;
    logic        hreadyout;
    logic        hresp;
  } ahb_rsp_t;

  typedef struct packed {
    logic [7:0] gpio_out_en_n;
    logic [7:0] pad_pullup_enable;
    logic [7:0] gpio_push_enable;
    logic [7:0] pad_hold_control;
  } pad_ctrl_t;

endpackage : pcr_pkg
`default_nettype wire

// *** logic/clock_divider.sv ***
// glitch-free cpu clock enable generator: selectable divide by 1, 2 or 4
// assumes the select input is already synchronous to hclk
`timescale 1ns/1ps
`default_nettype none
module clock_divider #(
  parameter int CNT_W = 2
) (
  // clock and reset
  input  wire logic             hclk,
  input  wire logic             hresetn,
  // control
  input  wire logic             run,
  input  wire logic [1:0]       sel,
  // tick out
  output logic                  tick
);

  typedef struct packed {
    logic [CNT_W-1:0] cnt;
    logic [1:0]       sel_live;
    logic             tick;
  } div_state_t;

  div_state_t s_q;
  div_state_t s_d;

  always_comb begin
    logic             wrap;
    wrap = 1'b0;
    s_d  = s_q;
    s_d.tick = 1'b0;
    if (run) begin
      s_d.cnt = s_q.cnt + 1'b1;
      case (s_q.sel_live)
        2'b01:   wrap = s_q.cnt[0];
        2'b10:   wrap = &s_q.cnt;
        default: wrap = 1'b1;
      endcase
      if (wrap) begin
        s_d.tick = 1'b1;
        s_d.cnt = '0;
        s_d.sel_live = sel; // rate changes only at a period boundary
      end
    end else begin
      s_d.cnt = '0;
      s_d.sel_live = sel;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign tick = s_q.tick;

endmodule : clock_divider
`default_nettype wire

// *** dv/pcr_checker_assertions.sv ***
// port checker for the power, clock and reset unit
// assumes it is bound into power_clock_reset_unit
`timescale 1ns/1ps
`default_nettype none
module pcr_checker
  import pcr_pkg::*;
#(
  parameter int GLITCH_CYCLES = 8
) (
  // clock and reset
  input wire logic       hclk,
  input wire logic       hresetn,
  // watched ports
  input wire ahb_rsp_t   ahb_rsp,
  input wire logic       supply_ok,
  input wire logic       supply_glitch_low,
  input wire logic       hard_power_down_n,
  input wire logic [7:0] gpio_value,
  input wire logic       cpu_clk_tick,
  input wire logic       uart_clk_en,
  input wire logic       internal_reset,
  input wire logic       reset_out_n,
  input wire logic       regulator_soft_pd,
  input wire logic       ports_disconnect,
  input wire pad_ctrl_t  pad_ctrl
);
  // length of the current supply dip
  int gl_q;
  int gl_d;
  always_comb gl_d = !supply_glitch_low ? 0 : (gl_q > GLITCH_CYCLES + 8) ? gl_q : gl_q + 1;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) gl_q <= 0;
    else gl_q <= gl_d;
  end
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  sequence s_hpd; !hard_power_down_n [*4]; endsequence
  sequence s_low; !supply_ok [*4]; endsequence
  property p_okay; ahb_rsp.hresp == 1'b0 && ahb_rsp.hreadyout; endproperty
  a_okay: assert property (p_okay) else $error("bus answer not okay");
  property p_rst; internal_reset |-> !reset_out_n; endproperty
  a_rst: assert property (p_rst) else $error("reset out high in reset");
  property p_hpd; s_hpd |-> internal_reset && !reset_out_n && ports_disconnect; endproperty
  a_hpd: assert property (p_hpd) else $error("hard power-down not in reset");
  property p_pads; s_hpd |-> pad_ctrl.gpio_out_en_n == 8'hff && pad_ctrl.pad_pullup_enable == 8'hff
    && pad_ctrl.gpio_push_enable == 8'h00; endproperty
  a_pads: assert property (p_pads) else $error("pads not quasi-bidirectional");
  property p_hold; (!hard_power_down_n && $stable(gpio_value)) [*5] |-> pad_ctrl.pad_hold_control == gpio_value;
  endproperty
  a_hold: assert property (p_hold) else $error("hold does not follow pad");
  property p_low; s_low |-> internal_reset && !cpu_clk_tick && !uart_clk_en; endproperty
  a_low: assert property (p_low) else $error("clocks run on low supply");
  property p_rise; $rose(reset_out_n) |-> $past(supply_ok, 16) && $past(hard_power_down_n, 16); endproperty
  a_rise: assert property (p_rise) else $error("reset out rose early");
  property p_stop; regulator_soft_pd |-> !cpu_clk_tick && !uart_clk_en; endproperty
  a_stop: assert property (p_stop) else $error("clock runs while stopped");
  property p_glitch; gl_q > GLITCH_CYCLES + 4 |-> internal_reset && !reset_out_n; endproperty
  a_glitch: assert property (p_glitch) else $error("long dip gave no reset");
endmodule : pcr_checker

bind power_clock_reset_unit pcr_checker #(
  .GLITCH_CYCLES (GLITCH_CYCLES)
) chk_u (
  .hclk              (hclk),
  .hresetn           (hresetn),
  .ahb_rsp           (ahb_rsp),
  .supply_ok         (supply_ok),
  .supply_glitch_low (supply_glitch_low),
  .hard_power_down_n (hard_power_down_n),
  .gpio_value        (gpio_value),
  .cpu_clk_tick      (cpu_clk_tick),
  .uart_clk_en       (uart_clk_en),
  .internal_reset    (internal_reset),
  .reset_out_n       (reset_out_n),
  .regulator_soft_pd (regulator_soft_pd),
  .ports_disconnect  (ports_disconnect),
  .pad_ctrl          (pad_ctrl)
);
`default_nettype wire

// *** dv/cpu_bus_model.sv ***
// firmware side: single-word ahb-lite master
// assumes hreadyout of the one slave is the bus hready
`timescale 1ns/1ps
`default_nettype none
module cpu_bus_model
  import pcr_pkg::*;
(
  // clock
  input  wire logic     hclk,
  // bus
  output ahb_req_t      ahb_req,
  input  wire ahb_rsp_t ahb_rsp
);
  ahb_req_t q;
  initial q = '0;
  always_comb begin
    ahb_req        = q;
    ahb_req.hready = ahb_rsp.hreadyout;
  end
  // callers set wake enables before the request bit
  task automatic xfer(input logic w, input logic [15:0] idx, input logic [7:0] wd, output logic [7:0] rd);
    q.hsel   <= 1'b1;
    q.haddr  <= {14'h0, idx, 2'b00};
    q.htrans <= 2'b10;
    q.hwrite <= w;
    q.hsize  <= 3'b010;
    do @(posedge hclk); while (ahb_rsp.hreadyout !== 1'b1);
    q.htrans <= 2'b00;
    q.hwdata <= {24'h0, wd};
    do @(posedge hclk); while (ahb_rsp.hreadyout !== 1'b1);
    rd = ahb_rsp.hrdata[7:0];
    q.hsel   <= 1'b0;
    q.hwdata <= ~q.hwdata;
    @(posedge hclk);
  endtask : xfer
endmodule : cpu_bus_model
`default_nettype wire

// *** dv/testbench.sv ***
// self-checking bench for the power, clock and reset unit
// assumes short glitch and start-up counts of 8 cycles
`timescale 1ns/1ps
`default_nettype none
`include "pcr_regs.svh"
module testbench
  import pcr_pkg::*;
;
  logic       hclk, hresetn, supply_ok, supply_glitch_low, hard_power_down_n;
  logic [7:0] wake_src, gpio_value, rv;
  ahb_req_t   ahb_req;
  ahb_rsp_t   ahb_rsp;
  pad_ctrl_t  pad_ctrl;
  logic       cpu_clk_tick, uart_clk_en, internal_reset, reset_out_n, regulator_soft_pd, ports_disconnect;
  int         n_errors = 0;
  int         cmp_count = 0;
  int         k;

  power_clock_reset_unit #(
    .GLITCH_CYCLES  (8),
    .STARTUP_CYCLES (8),
    .PWRUP_CYCLES   (16)
  ) dut_u (
    .hclk              (hclk),
    .hresetn           (hresetn),
    .ahb_req           (ahb_req),
    .ahb_rsp           (ahb_rsp),
    .supply_ok         (supply_ok),
    .supply_glitch_low (supply_glitch_low),
    .hard_power_down_n (hard_power_down_n),
    .wake_src          (wake_src),
    .gpio_value        (gpio_value),
    .cpu_clk_tick      (cpu_clk_tick),
    .uart_clk_en       (uart_clk_en),
    .internal_reset    (internal_reset),
    .reset_out_n       (reset_out_n),
    .regulator_soft_pd (regulator_soft_pd),
    .ports_disconnect  (ports_disconnect),
    .pad_ctrl          (pad_ctrl)
  );
  cpu_bus_model bus_u (
    .hclk    (hclk),
    .ahb_req (ahb_req),
    .ahb_rsp (ahb_rsp)
  );

  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    cmp_count++;
    if (g !== e) begin
      n_errors++;
      $display("ERROR %s expected %h seen %h", n, e, g);
    end
  endtask : chk
  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    bus_u.xfer(1'b1, a, d, rv);
  endtask : wr
  task automatic rdc(input logic [15:0] a, input logic [7:0] e);
    bus_u.xfer(1'b0, a, 8'h00, rv);
    chk($sformatf("reg %h", a), 32'(e), 32'(rv));
  endtask : rdc
  task automatic ticks(input int n);
    k = 0;
    repeat (n) begin
      @(posedge hclk);
      if (cpu_clk_tick === 1'b1) k++;
    end
  endtask : ticks
  task automatic wait_up;
    repeat (80) if (reset_out_n !== 1'b1) @(posedge hclk);
    chk("reset_out_n", 1, 32'(reset_out_n));
  endtask : wait_up
  task automatic t_regs;
    rdc(`OFS_CPU_CLOCK_SELECT, `RST_CPU_CLOCK_SELECT);
    rdc(`OFS_PERIPHERAL_CLOCK_GATE, `RST_PERIPHERAL_CLOCK_GATE);
    rdc(`OFS_WAKE_LEVEL_SELECT, `RST_WAKE_LEVEL_SELECT);
    rdc(`OFS_POWER_CONTROL, `RST_POWER_CONTROL);
    rdc(`OFS_WAKE_SOURCE_ENABLE, `RST_WAKE_SOURCE_ENABLE);
    wr(`OFS_POWER_STATUS, 8'hff);
    rdc(`OFS_POWER_STATUS, 8'h02);
    rdc(16'h6207, 8'h00);
  endtask : t_regs
  task automatic t_clocks;
    for (int s = 0; s < 4; s++) begin
      wr(`OFS_CPU_CLOCK_SELECT, 8'hfc | 8'(s));
      rdc(`OFS_CPU_CLOCK_SELECT, 8'(s));
      ticks(32);
      chk("ticks", (s == 1) ? 16 : (s == 2) ? 8 : 32, k);
    end
    wr(`OFS_PERIPHERAL_CLOCK_GATE, 8'h00);
    chk("uart_clk_en", 0, 32'(uart_clk_en));
    rdc(`OFS_PERIPHERAL_CLOCK_GATE, 8'h06);
    wr(`OFS_PERIPHERAL_CLOCK_GATE, 8'hff);
    chk("uart_clk_en", 1, 32'(uart_clk_en));
  endtask : t_clocks
  task automatic t_pd;
    logic [7:0] lv;
    logic [7:0] idle;
    logic [7:0] src;
    logic [7:0] other;
    // last three passes repeat sources 0..2 with their levels inverted
    for (int i = 0; i < 11; i++) begin
      lv    = (i < 8) ? 8'h00 : 8'h07;
      idle  = 8'h04 ^ lv;
      src   = 8'(1 << (i % 8));
      other = 8'(1 << ((i + 1) % 8));
      wr(`OFS_WAKE_LEVEL_SELECT, lv);
      wake_src <= idle;
      rdc(`OFS_WAKE_LEVEL_SELECT, lv);
      wr(`OFS_WAKE_SOURCE_ENABLE, src);
      wake_src <= idle ^ src;
      repeat (4) @(posedge hclk);
      wake_src <= idle;
      wr(`OFS_PD_REQUEST, 8'h01);
      repeat (40) if (regulator_soft_pd !== 1'b1) @(posedge hclk);
      wake_src <= idle ^ other;
      ticks(20);
      chk("stopped ticks", 0, k);
      chk("regulator_soft_pd", 1, 32'(regulator_soft_pd));
      wake_src <= idle ^ src ^ other;
      repeat (40) if (cpu_clk_tick !== 1'b1) @(posedge hclk);
      chk("wake tick", 1, 32'(cpu_clk_tick));
      wake_src <= idle;
      repeat (4) @(posedge hclk);
      rdc(`OFS_PD_REQUEST, 8'h00);
      rdc(`OFS_POWER_STATUS, 8'h02);
    end
  endtask : t_pd
  task automatic t_resets;
    gpio_value <= 8'ha5;
    hard_power_down_n <= 1'b0;
    repeat (6) @(posedge hclk);
    chk("ports_disconnect", 1, 32'(ports_disconnect));
    chk("pad_ctrl", 32'hffff_00a5, pad_ctrl);
    hard_power_down_n <= 1'b1;
    wait_up();
    rdc(`OFS_CPU_CLOCK_SELECT, `RST_CPU_CLOCK_SELECT);
    supply_ok <= 1'b0;
    repeat (4) @(posedge hclk);
    ticks(16);
    chk("low ticks", 0, k);
    supply_ok <= 1'b1;
    repeat (17) @(posedge hclk);
    chk("reset_out_n", 0, 32'(reset_out_n));
    wait_up();
    wr(`OFS_WAKE_LEVEL_SELECT, 8'h00);
    supply_glitch_low <= 1'b1;
    repeat (4) @(posedge hclk);
    supply_glitch_low <= 1'b0;
    repeat (4) @(posedge hclk);
    chk("reset_out_n", 1, 32'(reset_out_n));
    supply_glitch_low <= 1'b1;
    repeat (20) @(posedge hclk);
    chk("reset_out_n", 0, 32'(reset_out_n));
    supply_glitch_low <= 1'b0;
    wait_up();
    rdc(`OFS_WAKE_LEVEL_SELECT, `RST_WAKE_LEVEL_SELECT);
  endtask : t_resets
  task automatic results;
    if (n_errors == 0 && cmp_count > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : results

  initial begin
    hclk = 1'b0;
    forever #10 hclk = ~hclk;
  end
  initial begin
    repeat (20000) @(posedge hclk);
    n_errors++;
    results();
  end
  initial begin
    hresetn = 1'b0;
    supply_ok = 1'b1;
    supply_glitch_low = 1'b0;
    hard_power_down_n = 1'b1;
    wake_src = 8'h04;
    gpio_value = 8'h00;
    repeat (16) @(posedge hclk);
    hresetn <= 1'b1;
    wait_up();
    t_regs();
    t_clocks();
    t_pd();
    t_resets();
    results();
  end
endmodule : testbench
`default_nettype wire
